// *** verilog/frt_timer.sv ***
// Free-running 16-bit capture/compare timer with APB register access
//
// Implementation choices: the register offsets and the APB register port.
`include "frt_consts.svh"
`default_nettype none
module frt_timer
  import frt_pkg::*;
#(
  parameter int DIV_W = `FRT_DIV_W
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Low-power hold from the power controller
  input  wire logic        lp_hold,
  // Capture and clock pins
  input  wire logic        capture_pin_a,
  input  wire logic        capture_pin_b,
  input  wire logic        capture_pin_c,
  input  wire logic        capture_pin_d,
  input  wire logic        ext_clk_pin,
  // Compare pins
  output logic             compare_out_pin_a,
  output logic             compare_out_pin_b,
  output logic             compare_oe_a,
  output logic             compare_oe_b,
  // Interrupt requests, one shared vector
  output logic [6:0]       irq_req,
  output logic             irq_any
);
  logic [4:0]       lvl, rise, fall;
  frt_word_t        cnt_q, cnt_d;
  frt_word_t        cmp_q [2], cmp_d [2];
  frt_word_t        cap_q [4], cap_d [4];
  logic [7:0]       temp_q, temp_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic             prev_q, prev_d;
  logic [3:0]       pend_q, pend_d;
  frt_ctrl_t        ctrl_q, ctrl_d;
  frt_outc_t        outc_q, outc_d;
  frt_stat_t        stat_q, stat_d;
  logic [6:0]       ier_q, ier_d;
  logic [6:0]       irq_q, irq_d;
  logic             irqa_q, irqa_d;
  logic             pina_q, pina_d, pinb_q, pinb_d;
  logic [7:0]       rdat_q, rdat_d;
  logic             err_q, err_d;
  logic             rdy_q;

  logic        setup, wr, hit, sel_lvl, tick, clr, ovf_ev;
  logic        wlo_cnt, whi_cnt, whi_cmp, match_a, match_b;
  logic [1:0]  wlo_cmp, buf_en;
  logic [3:0]  ev, raw, blk, stb, rd_hi;
  logic [6:0]  set_v, clr_v, flg_v;
  logic [7:0]  rdat;

  // Pins A..D then the external clock
  frt_pin_sync #(.N(5)) u_sync (
    .clk    (pclk),
    .rst_n  (presetn),
    .pin_in ({ext_clk_pin, capture_pin_d, capture_pin_c,
              capture_pin_b, capture_pin_a}),
    .level  (lvl),
    .rise   (rise),
    .fall   (fall)
  );

  always_comb begin
    setup   = psel && !penable;
    wr      = psel && penable && pwrite;
    whi_cnt = wr && paddr == `FRT_ADR_CNT_HI;
    wlo_cnt = wr && paddr == `FRT_ADR_CNT_LO;
    whi_cmp = wr && paddr == `FRT_ADR_CMP_HI;
    wlo_cmp[0] = wr && paddr == `FRT_ADR_CMP_LO && !outc_q.cmp_sel_b;
    wlo_cmp[1] = wr && paddr == `FRT_ADR_CMP_LO && outc_q.cmp_sel_b;
    buf_en  = {ctrl_q.buffer_enable_b, ctrl_q.buffer_enable_a};
    for (int i = 0; i < 4; i++) begin
      rd_hi[i] = psel && !pwrite &&
                 paddr == 8'(`FRT_ADR_CAP_HI + `FRT_CAP_STRIDE * i);
    end
    cnt_d  = cnt_q;
    cmp_d  = cmp_q;
    cap_d  = cap_q;
    temp_d = temp_q;
    ctrl_d = ctrl_q;
    outc_d = outc_q;
    ier_d  = ier_q;
    div_d  = DIV_W'(div_q + 1'b1);
    // Prescaler taps count on their falling edge, so a tap switch that
    // lands high-to-low adds one count; external uses the inverted level
    unique case (ctrl_q.clk_sel)
      `FRT_CKS_DIV2:  sel_lvl = div_q[`FRT_TAP_DIV2];
      `FRT_CKS_DIV8:  sel_lvl = div_q[`FRT_TAP_DIV8];
      `FRT_CKS_DIV32: sel_lvl = div_q[`FRT_TAP_DIV32];
      `FRT_CKS_EXT:   sel_lvl = ~lvl[4];
    endcase
    prev_d = sel_lvl;
    tick   = prev_q && !sel_lvl;
    // Equality alone does nothing; strobe waits for the leaving tick
    match_a = tick && cnt_q == cmp_q[0] && !wlo_cmp[0];
    match_b = tick && cnt_q == cmp_q[1] && !wlo_cmp[1];
    clr     = match_a && stat_q.clear_on_match_a;
    if (clr) begin
      cnt_d = `FRT_RST_WORD;
    end else if (wlo_cnt) begin
      cnt_d = {temp_q, pwdata[7:0]};
    end else if (tick) begin
      cnt_d = cnt_q + 16'h0001;
    end
    ovf_ev = tick && cnt_q == `FRT_CNT_MAX && !clr && !wlo_cnt;
    pina_d = match_a ? outc_q.out_level_a : pina_q;
    pinb_d = match_b ? outc_q.out_level_b : pinb_q;
    // Edge events; in buffered mode C and D watch pins A and B
    for (int i = 0; i < 4; i++) begin
      if (i >= 2 && buf_en[i-2]) begin
        ev[i] = ctrl_q.edge_sel[i] ? rise[i-2] : fall[i-2];
      end else begin
        ev[i] = ctrl_q.edge_sel[i] ? rise[i] : fall[i];
      end
    end
    for (int i = 0; i < 2; i++) begin
      raw[i]   = ev[i] || (buf_en[i] && ev[i+2]);
      raw[i+2] = ev[i+2];
      blk[i]   = rd_hi[i] || (buf_en[i] && rd_hi[i+2]);
      blk[i+2] = buf_en[i] ? blk[i] : rd_hi[i+2];
    end
    // A read lasting two cycles can push the strobe past one clock
    stb    = (raw | pend_q) & ~blk;
    pend_d = (raw | pend_q) & blk;
    for (int i = 0; i < 2; i++) begin
      if (stb[i]) begin
        cap_d[i] = cnt_q;
        if (buf_en[i]) begin
          cap_d[i+2] = cap_q[i];
        end
      end
      if (stb[i+2] && !buf_en[i]) begin
        cap_d[i+2] = cnt_q;
      end
    end
    // Register writes
    if (whi_cnt || whi_cmp) begin
      temp_d = pwdata[7:0];
    end
    if (wlo_cmp[0]) begin
      cmp_d[0] = {temp_q, pwdata[7:0]};
    end
    if (wlo_cmp[1]) begin
      cmp_d[1] = {temp_q, pwdata[7:0]};
    end
    if (wr && paddr == `FRT_ADR_IER) begin
      ier_d = pwdata[6:0];
    end
    if (wr && paddr == `FRT_ADR_CTRL) begin
      ctrl_d = pwdata[7:0];
    end
    if (wr && paddr == `FRT_ADR_OUTC) begin
      outc_d = {3'h7, pwdata[4:0]};
    end
    // Flags: bit order cap A..D, compare A, compare B, overflow
    set_v = {ovf_ev, match_b, match_a, stb};
    clr_v = '0;
    if (wr && paddr == `FRT_ADR_STAT) begin
      clr_v = ~{pwdata[1], pwdata[2], pwdata[3], pwdata[7:4]};
    end
    flg_v = {stat_q.overflow_flag, stat_q.compare_flag_b,
             stat_q.compare_flag_a, stat_q.cap_flag};
    flg_v = (flg_v & ~clr_v) | set_v;
    stat_d.cap_flag       = flg_v[3:0];
    stat_d.compare_flag_a = flg_v[4];
    stat_d.compare_flag_b = flg_v[5];
    stat_d.overflow_flag  = flg_v[6];
    stat_d.clear_on_match_a = (wr && paddr == `FRT_ADR_STAT) ?
                              pwdata[0] : stat_q.clear_on_match_a;
    irq_d  = flg_v & ier_d;
    irqa_d = |irq_d;
    // Read data is built in the setup cycle
    hit  = 1'b1;
    rdat = 8'h00;
    unique case (paddr)
      `FRT_ADR_CNT_HI: rdat = cnt_q[15:8];
      `FRT_ADR_CNT_LO: rdat = temp_q;
      `FRT_ADR_CMP_HI: rdat = cmp_q[outc_q.cmp_sel_b][15:8];
      `FRT_ADR_CMP_LO: rdat = cmp_q[outc_q.cmp_sel_b][7:0];
      `FRT_ADR_IER:    rdat = {1'b0, ier_q};
      `FRT_ADR_CTRL:   rdat = ctrl_q;
      `FRT_ADR_OUTC:   rdat = outc_q;
      `FRT_ADR_STAT:   rdat = stat_q;
      default:         hit = 1'b0;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (paddr == 8'(`FRT_ADR_CAP_HI + `FRT_CAP_STRIDE * i)) begin
        hit  = 1'b1;
        rdat = cap_q[i][15:8];
      end
      if (paddr == 8'(`FRT_ADR_CAP_LO + `FRT_CAP_STRIDE * i)) begin
        hit  = 1'b1;
        rdat = temp_q;
      end
    end
    if (setup && !pwrite && paddr == `FRT_ADR_CNT_HI) begin
      temp_d = cnt_q[7:0];
    end
    for (int i = 0; i < 4; i++) begin
      if (setup && rd_hi[i]) begin
        temp_d = cap_q[i][7:0];
      end
    end
    rdat_d = setup ? rdat : rdat_q;
    err_d  = setup ? !hit : err_q;
    // Low-power modes hold the timer in reset, all but the APB read data, error and ready registers and the pin synchronisers
    if (lp_hold) begin
      cnt_d  = `FRT_RST_WORD;
      cmp_d  = '{default: `FRT_RST_WORD};
      cap_d  = '{default: `FRT_RST_WORD};
      temp_d = 8'h00;
      div_d  = '0;
      prev_d = 1'b0;
      pend_d = 4'h0;
      ctrl_d = `FRT_RST_CTRL;
      outc_d = `FRT_RST_OUTC;
      stat_d = `FRT_RST_STAT;
      ier_d  = `FRT_RST_IER;
      irq_d  = 7'h00;
      irqa_d = 1'b0;
      pina_d = 1'b0;
      pinb_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= `FRT_RST_WORD;
      cmp_q  <= '{default: `FRT_RST_WORD};
      cap_q  <= '{default: `FRT_RST_WORD};
      temp_q <= 8'h00;
      div_q  <= '0;
      prev_q <= 1'b0;
      pend_q <= 4'h0;
      ctrl_q <= `FRT_RST_CTRL;
      outc_q <= `FRT_RST_OUTC;
      stat_q <= `FRT_RST_STAT;
      ier_q  <= `FRT_RST_IER;
      irq_q  <= 7'h00;
      irqa_q <= 1'b0;
      pina_q <= 1'b0;
      pinb_q <= 1'b0;
      rdat_q <= 8'h00;
      err_q  <= 1'b0;
      rdy_q  <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      cmp_q  <= cmp_d;
      cap_q  <= cap_d;
      temp_q <= temp_d;
      div_q  <= div_d;
      prev_q <= prev_d;
      pend_q <= pend_d;
      ctrl_q <= ctrl_d;
      outc_q <= outc_d;
      stat_q <= stat_d;
      ier_q  <= ier_d;
      irq_q  <= irq_d;
      irqa_q <= irqa_d;
      pina_q <= pina_d;
      pinb_q <= pinb_d;
      rdat_q <= rdat_d;
      err_q  <= err_d;
      rdy_q  <= 1'b1;
    end
  end

  assign prdata            = {24'h000000, rdat_q};
  assign pready            = rdy_q;
  assign pslverr           = err_q;
  assign compare_out_pin_a = pina_q;
  assign compare_out_pin_b = pinb_q;
  assign compare_oe_a      = outc_q.oe_a;
  assign compare_oe_b      = outc_q.oe_b;
  assign irq_req           = irq_q;
  assign irq_any           = irqa_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ovf_wrap: assert property (ovf_ev && !lp_hold |=>
    stat_q.overflow_flag && cnt_q == `FRT_RST_WORD)
    else $error("overflow flag not set on wrap");
  a_cmp_strobe: assert property (match_a && !lp_hold |=>
    stat_q.compare_flag_a && compare_out_pin_a == $past(outc_q.out_level_a))
    else $error("compare A match missed");
  a_no_early: assert property (!tick && !stat_q.compare_flag_a && !wr
    && !lp_hold |=> !stat_q.compare_flag_a)
    else $error("compare flag set without counter clock");
  a_cap_load: assert property (stb[0] && !lp_hold |=>
    cap_q[0] == $past(cnt_q) && stat_q.cap_flag[0])
    else $error("capture A load and flag mismatch");
  a_cap_delay: assert property ((raw[0] && blk[0] && !lp_hold |=>
    !blk[0] ##0 stb[0]) or (raw[0] && blk[0] |=> blk[0]))
    else $error("blocked capture not delayed one clock");
  a_clear_wins: assert property (clr && wlo_cnt && !lp_hold |=>
    cnt_q == `FRT_RST_WORD)
    else $error("counter write beat clear");
  a_write_wins: assert property (tick && wlo_cnt && !clr && !lp_hold |=>
    cnt_q == {$past(temp_q), $past(pwdata[7:0])})
    else $error("increment beat counter write");
  a_cmp_supp: assert property (wlo_cmp[1] && !stat_q.compare_flag_b
    && !lp_hold |=> !stat_q.compare_flag_b)
    else $error("compare strobe during compare write");
  a_hold_reset: assert property (lp_hold |=>
    cnt_q == `FRT_RST_WORD && stat_q == `FRT_RST_STAT && !compare_out_pin_a)
    else $error("timer not held in low-power mode");
  a_irq_gate: assert property (!ier_q[6] &&
    !(wr && paddr == `FRT_ADR_IER) |=> !irq_req[6])
    else $error("disabled overflow source raised request");
  a_buf_shift: assert property (stb[0] && buf_en[0] && !lp_hold |=>
    cap_q[2] == $past(cap_q[0]))
    else $error("buffered capture did not shift");

  c_capture_a:  cover property (stb[0]);
  c_delayed:    cover property (raw[0] && blk[0] ##1 stb[0]);
  c_overflow:   cover property (ovf_ev);
  c_match_b:    cover property (match_b);
endmodule
`default_nettype wire

// *** inc/frt_consts.svh ***
// Register offsets, reset values and field constants of the capture/compare timer
`ifndef FRT_CONSTS_SVH
`define FRT_CONSTS_SVH
`define FRT_ADR_CNT_HI  8'h00
`define FRT_ADR_CNT_LO  8'h04
`define FRT_ADR_CMP_HI  8'h08
`define FRT_ADR_CMP_LO  8'h0C
`define FRT_ADR_CAP_HI  8'h10
`define FRT_ADR_CAP_LO  8'h14
`define FRT_CAP_STRIDE  8'h08
`define FRT_ADR_IER     8'h30
`define FRT_ADR_CTRL    8'h34
`define FRT_ADR_OUTC    8'h38
`define FRT_ADR_STAT    8'h3C
`define FRT_RST_CTRL    8'h00
`define FRT_RST_OUTC    8'hE0
`define FRT_RST_STAT    8'h00
`define FRT_RST_IER     7'h00
`define FRT_RST_WORD    16'h0000
`define FRT_CNT_MAX     16'hFFFF
`define FRT_CKS_DIV2    2'h0
`define FRT_CKS_DIV8    2'h1
`define FRT_CKS_DIV32   2'h2
`define FRT_CKS_EXT     2'h3
`define FRT_TAP_DIV2    0
`define FRT_TAP_DIV8    2
`define FRT_TAP_DIV32   4
`define FRT_DIV_W       5
`define FRT_N_SRC       7
`endif

// *** inc/frt_pkg.sv ***
// Types of the capture/compare timer
`default_nettype none
package frt_pkg;
  typedef logic [15:0] frt_word_t;
  // Bits 7:4 edge select (bit 4 is channel A), 3 buffer A, 2 buffer B
  typedef struct packed {
    logic [3:0] edge_sel;
    logic       buffer_enable_a;
    logic       buffer_enable_b;
    logic [1:0] clk_sel;
  } frt_ctrl_t;
  typedef struct packed {
    logic [2:0] rsvd;
    logic       cmp_sel_b;
    logic       oe_a;
    logic       oe_b;
    logic       out_level_a;
    logic       out_level_b;
  } frt_outc_t;
  typedef struct packed {
    logic [3:0] cap_flag;
    logic       compare_flag_a;
    logic       compare_flag_b;
    logic       overflow_flag;
    logic       clear_on_match_a;
  } frt_stat_t;
endpackage
`default_nettype wire

// *** verilog/frt_pin_sync.sv ***
// Two-stage synchronisers with edge detection for the timer input pins
`default_nettype none
module frt_pin_sync #(
  parameter int N = 5
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pins and detected events
  input  wire logic [N-1:0] pin_in,
  output logic      [N-1:0] level,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);
  logic [N-1:0] s1_q, s2_q, s3_q;
  logic [N-1:0] s1_d, s2_d, s3_d;

  always_comb begin
    s1_d = pin_in;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // Only the second stage and later feed logic
  assign level = s2_q;
  assign rise  = s2_q & ~s3_q;
  assign fall  = ~s2_q & s3_q;
endmodule
`default_nettype wire

// *** tb/frt_pin_model.sv ***
// Far-side model of the capture pins and the external count clock
`default_nettype none
module frt_pin_model (
  // Clock
  input  wire logic       pclk,
  // Pins toward the timer
  output logic      [3:0] cap_pins,
  output logic            ext_clk
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cap_pins = 4'h0;
    ext_clk  = 1'h0;
  end

  // Pins move just after an edge; the timer synchronises them anyway
  task automatic set_pin(input int ch, input logic v);
    @(posedge pclk);
    cap_pins[ch] <= v;
  endtask

  // Count clock rests low between pulses; high time above 1.5 clocks
  task automatic ext_pulse(input int hi);
    @(posedge pclk);
    ext_clk <= 1'h1;
    repeat (hi) @(posedge pclk);
    ext_clk <= 1'h0;
    repeat (hi) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// *** tb/frt_timer_bench.sv ***
// Self-checking bench for the capture/compare timer
`include "frt_consts.svh"
`default_nettype none
module frt_timer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    string       nm;
    logic [15:0] v;
  } frt_note_t;

  logic        pclk    = 1'h0;
  logic        presetn = 1'h0;
  logic        psel    = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite  = 1'h0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        lp_hold = 1'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, ext_clk, irq_any;
  logic        pin_a, pin_b, oe_a, oe_b;
  logic [3:0]  cap;
  logic [6:0]  irq_req;
  logic [7:0]  rq, re, hi, lo;
  logic [7:0]  lfsr = 8'h62;
  int          mismatches = 0;
  int          n_compared = 0;
  frt_note_t   exp_q[$];
  logic [15:0] seen_q[$];
  frt_note_t   cur;

  always #25 pclk = ~pclk;

  frt_timer frt_timer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lp_hold(lp_hold),
    .capture_pin_a(cap[0]), .capture_pin_b(cap[1]),
    .capture_pin_c(cap[2]), .capture_pin_d(cap[3]),
    .ext_clk_pin(ext_clk), .compare_out_pin_a(pin_a),
    .compare_out_pin_b(pin_b), .compare_oe_a(oe_a), .compare_oe_b(oe_b),
    .irq_req(irq_req), .irq_any(irq_any)
  );
  frt_pin_model frt_pin_model_i (
    .pclk(pclk), .cap_pins(cap), .ext_clk(ext_clk)
  );

  task automatic check(string nm, logic [15:0] exp, logic [15:0] seen);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic note(string nm, logic [15:0] exp, logic [15:0] seen);
    exp_q.push_back('{nm: nm, v: exp});
    seen_q.push_back(seen);
  endtask

  // Watcher takes the oldest note whenever a result shows up
  always @(posedge pclk) begin
    while (seen_q.size() > 0 && exp_q.size() > 0) begin
      cur = exp_q.pop_front();
      check(cur.nm, cur.v, seen_q.pop_front());
    end
  end

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One APB transfer; waits on pready under a bound
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      print_verdict();
    end else begin
      rq = prdata[7:0];
      re = {7'h00, pslverr};
      psel    <= 1'h0;
      penable <= 1'h0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask

  task automatic rd(string nm, input logic [7:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    note(nm, {8'h00, e}, {8'h00, rq});
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 8'h04, v[7:0]);
  endtask

  function automatic logic [7:0] nxt(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd("ctrl", `FRT_ADR_CTRL, `FRT_RST_CTRL);
    rd("outc", `FRT_ADR_OUTC, `FRT_RST_OUTC);
    // Counter leaves 0000 = both compare resets, so both compare flags set
    rd("stat", `FRT_ADR_STAT, 8'h0C);
    rd("ier", `FRT_ADR_IER, 8'h00);
    note("slverr_ok", 16'h0, {8'h00, re});
    bus(1'h0, 8'h40, 8'h00);
    note("slverr_bad", 16'h1, {8'h00, re});
    wr(`FRT_ADR_STAT, 8'h00);
    $display("Test reset done");
    // B and D capture on falling edges, so raise those pins first
    frt_pin_model_i.set_pin(1, 1'h1);
    frt_pin_model_i.set_pin(3, 1'h1);
    wr(`FRT_ADR_CTRL, 8'h53);
    wr(`FRT_ADR_IER, 8'h77);
    for (int ch = 0; ch < 4; ch++) begin
      wr16(`FRT_ADR_CNT_HI, 16'h1230 + 16'(ch));
      frt_pin_model_i.set_pin(ch, (ch % 2) == 0);
      repeat (8) @(posedge pclk);
      rd("cap_hi", 8'(`FRT_ADR_CAP_HI + 8 * ch), 8'h12);
      rd("cap_lo", 8'(`FRT_ADR_CAP_LO + 8 * ch), 8'(8'h30 + ch));
      rd("stat_cap", `FRT_ADR_STAT, 8'(8'h10 << ch));
      note("irq", {9'h0, 7'(7'h01 << ch) & 7'h77}, {9'h0, irq_req});
      note("irq_any", 16'(ch != 3), {15'h0, irq_any});
      wr(`FRT_ADR_STAT, 8'h00);
      repeat (2) @(posedge pclk);
      note("irq_clr", 16'h0, {9'h0, irq_req});
    end
    $display("Test capture done");
    // Buffered A: both edges of pin A, older value moves to C
    wr(`FRT_ADR_CTRL, 8'h1B);
    wr16(`FRT_ADR_CNT_HI, 16'h0100);
    frt_pin_model_i.set_pin(0, 1'h0);
    repeat (8) @(posedge pclk);
    rd("buf_c_hi", 8'h20, 8'h12);
    rd("buf_c_lo", 8'h24, 8'h30);
    // Edge through C also strobes capture A, so both flags are up
    rd("stat_c", `FRT_ADR_STAT, 8'h50);
    note("flag_c", 16'h1, {15'h0, rq[6]});
    wr16(`FRT_ADR_CNT_HI, 16'h0200);
    frt_pin_model_i.set_pin(0, 1'h1);
    repeat (8) @(posedge pclk);
    rd("buf_a_hi", `FRT_ADR_CAP_HI, 8'h02);
    rd("buf_c_hi2", 8'h20, 8'h01);
    $display("Test buffered done");
    // Compare A with clear on match, level high on the pin
    wr(`FRT_ADR_CTRL, 8'h03);
    wr(`FRT_ADR_STAT, 8'h01);
    wr(`FRT_ADR_OUTC, 8'h0A);
    wr16(`FRT_ADR_CMP_HI, 16'h0040);
    wr16(`FRT_ADR_CNT_HI, 16'h0040);
    repeat (4) @(posedge pclk);
    note("pin_a_early", 16'h0, {15'h0, pin_a});
    rd("stat_early", `FRT_ADR_STAT, 8'h01);
    frt_pin_model_i.ext_pulse(3);
    repeat (6) @(posedge pclk);
    rd("stat_cmp", `FRT_ADR_STAT, 8'h09);
    note("pin_a", 16'h1, {15'h0, pin_a});
    note("oe_a", 16'h1, {15'h0, oe_a});
    note("irq_cmp", 16'h10, {9'h0, irq_req});
    rd("cnt_clr_hi", `FRT_ADR_CNT_HI, 8'h00);
    rd("cnt_clr_lo", `FRT_ADR_CNT_LO, 8'h00);
    $display("Test compare done");
    // Overflow from the top count
    wr(`FRT_ADR_STAT, 8'h00);
    wr16(`FRT_ADR_CNT_HI, 16'hFFFF);
    frt_pin_model_i.ext_pulse(2);
    repeat (6) @(posedge pclk);
    rd("stat_ovf", `FRT_ADR_STAT, 8'h02);
    note("irq_ovf", 16'h40, {9'h0, irq_req});
    // Low byte only reaches the temp byte through an upper read
    rd("cnt_wrap_hi", `FRT_ADR_CNT_HI, 8'h00);
    rd("cnt_wrap", `FRT_ADR_CNT_LO, 8'h00);
    $display("Test overflow done");
    // Low-power hold returns all but the APB read data, error and ready registers and the pin synchronisers to reset values
    lp_hold <= 1'h1;
    repeat (3) @(posedge pclk);
    lp_hold <= 1'h0;
    @(posedge pclk);
    rd("ctrl_lp", `FRT_ADR_CTRL, 8'h00);
    rd("outc_lp", `FRT_ADR_OUTC, 8'hE0);
    // Compares back at 0000 match as the restarted counter leaves 0000
    rd("stat_lp", `FRT_ADR_STAT, 8'h0C);
    note("pin_a_lp", 16'h0, {15'h0, pin_a});
    $display("Test hold done");
    // Random words through the temp byte into compare B
    wr(`FRT_ADR_OUTC, 8'h10);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      hi = lfsr;
      lfsr = nxt(lfsr);
      lo = lfsr;
      wr16(`FRT_ADR_CMP_HI, {hi, lo});
      rd("cmp_hi", `FRT_ADR_CMP_HI, hi);
      rd("cmp_lo", `FRT_ADR_CMP_LO, lo);
    end
    $display("Test random done");
    repeat (4) @(posedge pclk);
    print_verdict();
  end
endmodule
`default_nettype wire
